// >>> rtl/garc_consts.vh
/*
 * constants for the guarded action register controller: register offsets,
 * field positions, reset values and timing counts.
 * assumes a plain register port with 32-bit data, byte addresses, 12-bit offsets.
 */
// Behaviour
// - guarded fields ignore writes unless their guarding field enables them.
// - table base guarded by its valid bit; affinity guarded by pe idle bit.
// - blocked guarded write changes nothing; optionally sets an error flag.
// - side-effects start only when a write sets the action bit to one; any pe select write while idle starts the pe action.
// - each action register has an idle status bit showing completion.
// - after idle, another action write retriggers without writing zero first.
// - write without action bit set triggers nothing, controlled state unchanged.
// - virtual pe registers keep addressing the last selected virtual pe.
// - 64-bit action register holds its action bit in one 32-bit half.
// - non-action half is kept; full 64-bit value used when action fires.
// - no exclusive or atomic read-modify-write support on registers.
// - frames answer in their domain space; management aliasing is optional.
`ifndef GARC_CONSTS_VH
`define GARC_CONSTS_VH

// ==========================================================
// register offsets
`define GARC_OFS_PE_SEL 12'h140
`define GARC_OFS_PE_STATUS 12'h144
`define GARC_OFS_BASE_LO 12'h180
`define GARC_OFS_BASE_HI 12'h184
`define GARC_OFS_VIRT_SEL_LO 12'h240
`define GARC_OFS_VIRT_SEL_HI 12'h244
`define GARC_OFS_VIRT_DB 12'h248
`define GARC_OFS_STATUS 12'h400
`define GARC_OFS_INT_STAT 12'h404
`define GARC_OFS_INT_MASK 12'h408

// ==========================================================
// field positions
`define GARC_BASE_VALID_BIT 0
`define GARC_PE_IDLE_BIT 0
`define GARC_VIRT_ACT_BIT 31
`define GARC_AFF_MSB 15
`define GARC_VIRT_ID_MSB 15
`define GARC_VIRT_DB_MSB 15
`define GARC_ST_VIRT_IDLE_BIT 1
`define GARC_ST_PE_IDLE_BIT 0
// interrupt status layout
`define GARC_EV_PE_DONE 0
`define GARC_EV_VIRT_DONE 1
`define GARC_EV_GUARD_ERR 2
`define GARC_EV_W 3

// ==========================================================
// reset values and timing
`define GARC_RST_32 32'h0000_0000
`define GARC_RST_16 16'h0000
`define GARC_RST_EV 3'h0
// side-effect time per action, in ns, and its cycle count at 25 ns
`define GARC_ACT_NS 200
`define GARC_CLK_NS 25
`define GARC_ACT_CYC ((`GARC_ACT_NS + `GARC_CLK_NS - 1) / `GARC_CLK_NS)
`define GARC_CNT_W 4

`endif

// >>> rtl/garc_action_engine.v
/*
 * one action engine: accepts a start pulse, runs a fixed-length side-effect
 * and reports idle. assumes start arrives only as a one-cycle pulse.
 */
`timescale 1ns/1ps
`include "garc_consts.vh"

module garc_action_engine (
    input wire mclk,
    input wire resetn,
    input wire start,
    output reg idle_q,
    output reg done_q
);

    reg [`GARC_CNT_W-1:0] cnt_q;
    // the cycle count is a 32-bit integer expression; only the counter width is loaded
    wire [31:0] act_cyc_w = `GARC_ACT_CYC;

    // ==========================================================
    // busy counter
    always @(posedge mclk) begin
        if (!resetn) begin
            idle_q <= 1'b1;
            done_q <= 1'b0;
            cnt_q <= {`GARC_CNT_W{1'b0}};
        end else begin
            done_q <= 1'b0;
            if (start) begin
                idle_q <= 1'b0;
                cnt_q <= act_cyc_w[`GARC_CNT_W-1:0];
            end else if (!idle_q) begin
                if (cnt_q == {{(`GARC_CNT_W-1){1'b0}}, 1'b1}) begin
                    idle_q <= 1'b1;
                    done_q <= 1'b1;
                end
                cnt_q <= cnt_q - {{(`GARC_CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

endmodule

// >>> rtl/garc_top.v
/*
 * register controller with guarded fields, action bits with idle tracking,
 * and 64-bit operand assembly from 32-bit halves. plain register port,
 * one clock, synchronous active-low reset. master never waits.
 */
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "garc_consts.vh"

module garc_top (
    input wire mclk,
    input wire resetn,
    input wire [11:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    input wire rd,
    output reg [31:0] rdata_q,
    output reg irq_q,
    output reg [15:0] pe_aff_q,
    output reg [63:0] base_q,
    output reg [15:0] virt_cur_q,
    output reg [63:0] virt_operand_q,
    output reg virt_start_q,
    output reg pe_start_q
);

    reg [31:0] virt_lo_q;
    reg [15:0] virt_db_q;
    reg [`GARC_EV_W-1:0] ev_stat_q;
    reg [`GARC_EV_W-1:0] ev_mask_q;
    reg [`GARC_EV_W-1:0] ev_set;
    reg pe_go;
    reg virt_go;
    reg guard_err;
    wire pe_idle;
    wire virt_idle;
    wire pe_done;
    wire virt_done;

    function hit;
        input [11:0] a;
        input [11:0] ofs;
        begin
            hit = (a == ofs);
        end
    endfunction

    // ==========================================================
    // action engines
    garc_action_engine u_pe_eng (
        .mclk(mclk),
        .resetn(resetn),
        .start(pe_go),
        .idle_q(pe_idle),
        .done_q(pe_done)
    );

    garc_action_engine u_virt_eng (
        .mclk(mclk),
        .resetn(resetn),
        .start(virt_go),
        .idle_q(virt_idle),
        .done_q(virt_done)
    );

    // ==========================================================
    // write decode
    // accesses are plain reads and writes; no exclusive or locked cycles exist
    always @* begin
        pe_go = 1'b0;
        virt_go = 1'b0;
        guard_err = 1'b0;
        if (wr) begin
            if (hit(addr, `GARC_OFS_PE_SEL)) begin
                // affinity write accepted only while idle
                if (pe_idle)
                    pe_go = 1'b1;
                else
                    guard_err = 1'b1;
            end
            if (hit(addr, `GARC_OFS_BASE_LO) || hit(addr, `GARC_OFS_BASE_HI)) begin
                // address only writable while valid is clear
                if (base_q[`GARC_BASE_VALID_BIT] && hit(addr, `GARC_OFS_BASE_HI))
                    guard_err = 1'b1;
            end
            if (hit(addr, `GARC_OFS_VIRT_SEL_HI) && wdata[`GARC_VIRT_ACT_BIT])
                virt_go = virt_idle;
        end
    end

    always @* begin
        ev_set = {`GARC_EV_W{1'b0}};
        ev_set[`GARC_EV_PE_DONE] = pe_done;
        ev_set[`GARC_EV_VIRT_DONE] = virt_done;
        ev_set[`GARC_EV_GUARD_ERR] = guard_err;
    end

    // ==========================================================
    // register state
    always @(posedge mclk) begin
        if (!resetn) begin
            pe_aff_q <= `GARC_RST_16;
            base_q <= {`GARC_RST_32, `GARC_RST_32};
            virt_lo_q <= `GARC_RST_32;
            virt_cur_q <= `GARC_RST_16;
            virt_operand_q <= {`GARC_RST_32, `GARC_RST_32};
            virt_db_q <= `GARC_RST_16;
            virt_start_q <= 1'b0;
            pe_start_q <= 1'b0;
            ev_stat_q <= `GARC_RST_EV;
            ev_mask_q <= `GARC_RST_EV;
        end else begin
            virt_start_q <= virt_go;
            pe_start_q <= pe_go;
            if (pe_go)
                pe_aff_q <= wdata[`GARC_AFF_MSB:0];
            if (wr && hit(addr, `GARC_OFS_BASE_LO)) begin
                // valid lives in the low half; address bits there follow the guard
                if (!base_q[`GARC_BASE_VALID_BIT])
                    base_q[31:0] <= wdata;
                else
                    base_q[`GARC_BASE_VALID_BIT] <= wdata[`GARC_BASE_VALID_BIT];
            end
            if (wr && hit(addr, `GARC_OFS_BASE_HI) && !base_q[`GARC_BASE_VALID_BIT])
                base_q[63:32] <= wdata;
            // non-action half retained as operand for later action
            if (wr && hit(addr, `GARC_OFS_VIRT_SEL_LO))
                virt_lo_q <= wdata;
            if (virt_go) begin
                virt_operand_q <= {wdata, virt_lo_q};
                virt_cur_q <= virt_lo_q[`GARC_VIRT_ID_MSB:0];
            end
            // dependent register applies to whichever vpe is current
            if (wr && hit(addr, `GARC_OFS_VIRT_DB))
                virt_db_q <= wdata[`GARC_VIRT_DB_MSB:0];
            if (wr && hit(addr, `GARC_OFS_INT_MASK))
                ev_mask_q <= wdata[`GARC_EV_W-1:0];
            // set beats write-one-to-clear in the same cycle
            if (wr && hit(addr, `GARC_OFS_INT_STAT))
                ev_stat_q <= (ev_stat_q & ~wdata[`GARC_EV_W-1:0]) | ev_set;
            else
                ev_stat_q <= ev_stat_q | ev_set;
        end
    end

    // ==========================================================
    // read path and interrupt
    always @(posedge mclk) begin
        if (!resetn) begin
            rdata_q <= `GARC_RST_32;
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(ev_stat_q & ev_mask_q);
            rdata_q <= `GARC_RST_32;
            if (rd) begin
                case (addr)
                    `GARC_OFS_PE_STATUS: rdata_q <= {31'h0, pe_idle};
                    `GARC_OFS_BASE_LO: rdata_q <= base_q[31:0];
                    `GARC_OFS_BASE_HI: rdata_q <= base_q[63:32];
                    `GARC_OFS_VIRT_SEL_LO: rdata_q <= virt_lo_q;
                    `GARC_OFS_VIRT_SEL_HI: rdata_q <= {16'h0, virt_cur_q};
                    `GARC_OFS_VIRT_DB: rdata_q <= {16'h0, virt_db_q};
                    `GARC_OFS_STATUS: rdata_q <= {30'h0, virt_idle, pe_idle};
                    `GARC_OFS_INT_STAT: rdata_q <= {29'h0, ev_stat_q};
                    `GARC_OFS_INT_MASK: rdata_q <= {29'h0, ev_mask_q};
                    // one frame in one space; no management alias is decoded
                    default: rdata_q <= `GARC_RST_32; // unmapped reads as zero
                endcase
            end
        end
    end

endmodule

// >>> testbench/garc_top_assertions.sv
/* port checker for garc_top.
   bound from the bench top file; sees only the top module's ports. */
`timescale 1ns/1ps
module garc_chk (
    input wire mclk,
    input wire resetn,
    input wire [11:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    input wire rd,
    input wire [31:0] rdata_q,
    input wire irq_q,
    input wire [15:0] pe_aff_q,
    input wire [63:0] base_q,
    input wire [15:0] virt_cur_q,
    input wire [63:0] virt_operand_q,
    input wire virt_start_q,
    input wire pe_start_q
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    // ======
    // properties
    a_pe_start_cause: assert property (pe_start_q |-> $past(wr && addr == 12'h140))
        else $error("pe start without a select write");
    a_virt_start_cause: assert property (virt_start_q |-> $past(wr && addr == 12'h244 && wdata[31]))
        else $error("virtual start without action bit");
    a_pe_busy_gap: assert property (pe_start_q |=> !pe_start_q [*8])
        else $error("pe action retriggered while busy");
    a_virt_cur_hold: assert property (!virt_start_q |-> $stable(virt_cur_q))
        else $error("virtual selection moved without action");
    a_operand_hold: assert property (!virt_start_q |-> $stable(virt_operand_q))
        else $error("operand moved without action");
    a_aff_guard: assert property ($changed(pe_aff_q) |-> pe_start_q)
        else $error("affinity changed without accepted write");
    a_base_frozen: assert property ($past(base_q[0]) |-> base_q[63:1] == $past(base_q[63:1]))
        else $error("base address changed while valid");
    a_rdata_idle: assert property (!$past(rd) |-> rdata_q == 32'h0)
        else $error("read data outside read answer cycle");
    c_pe: cover property (pe_start_q);
    c_virt: cover property (virt_start_q);
    c_irq: cover property (irq_q);
endmodule

// >>> testbench/garc_host.sv
/* software-side bus master model for garc_top.
   one access at a time on a plain strobe port; no waits from the slave. */
`timescale 1ns/1ps
module garc_host (
    input wire mclk,
    input wire [31:0] rdata_q,
    output logic [11:0] addr,
    output logic [31:0] wdata,
    output logic wr,
    output logic rd
);
    initial begin
        addr = 12'h0;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
    end
    // each access retires before the next starts
    task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        wdata <= ~d;
        @(negedge mclk);
    endtask
    task automatic rd_reg(input logic [11:0] a, output logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        @(negedge mclk);
        d = rdata_q;
    endtask
endmodule

// >>> testbench/garc_top_test.sv
/* self-checking bench for garc_top.
   drives the register port through garc_host; 40 MHz clock. */
`timescale 1ns/1ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin error_cnt++; \
    $display("ERROR %s exp %h got %h", n, e, s); end end
module garc_top_test;
    logic mclk;
    logic resetn;
    wire [11:0] addr;
    wire [31:0] wdata, rdata_q;
    wire wr, rd, irq_q, virt_start_q, pe_start_q;
    wire [15:0] pe_aff_q, virt_cur_q;
    wire [63:0] base_q, virt_operand_q;
    int error_cnt = 0;
    int compares = 0;
    logic [31:0] d;
    garc_host u_host (.mclk(mclk), .rdata_q(rdata_q), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
    garc_top u_dut (.mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata_q(rdata_q), .irq_q(irq_q), .pe_aff_q(pe_aff_q), .base_q(base_q),
        .virt_cur_q(virt_cur_q), .virt_operand_q(virt_operand_q),
        .virt_start_q(virt_start_q), .pe_start_q(pe_start_q));
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    task final_report;
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task t_pe;
        int i;
        u_host.wr_reg(12'h408, 32'h1);
        u_host.wr_reg(12'h140, 32'h1234);
        `CHK("pe_start", 1'b1, pe_start_q)
        u_host.rd_reg(12'h144, d);
        `CHK("pe idle busy", 1'b0, d[0])
        u_host.wr_reg(12'h140, 32'h5678);
        `CHK("aff blocked", 16'h1234, pe_aff_q)
        for (i = 0; i < 20 && d[0] !== 1'b1; i++) u_host.rd_reg(12'h144, d);
        `CHK("pe idle done", 1'b1, d[0])
        u_host.rd_reg(12'h404, d);
        `CHK("int stat", 32'h7, d)
        `CHK("irq on", 1'b1, irq_q)
        u_host.wr_reg(12'h404, 32'h7);
        u_host.rd_reg(12'h404, d);
        `CHK("int clear", 32'h0, d)
        `CHK("irq off", 1'b0, irq_q)
        u_host.wr_reg(12'h140, 32'h9abc);
        `CHK("aff retrigger", 16'h9abc, pe_aff_q)
    endtask
    task t_base;
        u_host.wr_reg(12'h180, 32'habcd_0000);
        u_host.wr_reg(12'h184, 32'h1);
        u_host.wr_reg(12'h180, 32'habcd_0001);
        u_host.wr_reg(12'h184, 32'h2);
        u_host.wr_reg(12'h180, 32'h1111_0001);
        `CHK("base valid", 64'h1_abcd_0001, base_q)
        u_host.wr_reg(12'h180, 32'h0);
        `CHK("base invalid", 64'h1_abcd_0000, base_q)
        u_host.rd_reg(12'h7f0, d);
        `CHK("unmapped", 32'h0, d)
    endtask
    task t_virt;
        u_host.rd_reg(12'h400, d);
        `CHK("status idle", 32'h3, d)
        u_host.wr_reg(12'h240, 32'h42);
        u_host.wr_reg(12'h244, 32'h8000_0007);
        `CHK("virt_start", 1'b1, virt_start_q)
        `CHK("operand", 64'h8000_0007_0000_0042, virt_operand_q)
        u_host.rd_reg(12'h400, d);
        `CHK("vpe busy", 1'b0, d[1])
        u_host.wr_reg(12'h240, 32'h99);
        u_host.wr_reg(12'h244, 32'h1);
        `CHK("virt kept", 16'h42, virt_cur_q)
        `CHK("operand kept", 64'h8000_0007_0000_0042, virt_operand_q)
        u_host.wr_reg(12'h248, 32'h55);
        u_host.rd_reg(12'h248, d);
        `CHK("vpe db", 32'h55, d)
    endtask
    initial begin
        #50000;
        error_cnt++;
        final_report;
    end
    initial begin
        resetn = 1'b0;
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        t_virt;
        t_pe;
        t_base;
        final_report;
    end
endmodule
bind garc_top garc_chk u_chk (.mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata_q(rdata_q), .irq_q(irq_q), .pe_aff_q(pe_aff_q), .base_q(base_q),
    .virt_cur_q(virt_cur_q), .virt_operand_q(virt_operand_q), .virt_start_q(virt_start_q),
    .pe_start_q(pe_start_q));
